// ===== rtl/priority_interrupt_controller.sv
// priority interrupt controller with wishbone register slave
//
// Local design decisions: the Wishbone interface to the registers and the register addresses.
`timescale 1ns/100ps
`include "ic_map.svh"

// Overview of operation
// - each user source has a 3-bit priority, 7 highest, 1 lowest enabled.
// - priority zero disables a source; it never requests.
// - graphics priority sits in bits 2:0, upper bits read zero.
// - reset sets every user source priority to level 4.
// - test bit 15 set while a pending request is blocked by cpu level.
// - test bit 13 selects vector field: highest pending or last acknowledged.
// - test bits 11:8 show the level of the presented request, 0 to 15.
// - test bits 6:0 hold a vector 0 to 118; bit 7 reads zero.
// - a request is taken only when above the current cpu level.
// - pending flags stay set until cleared, so requests repeat after return.
// - return restores the previous cpu level saved on entry.
// - trap flags stay set until cleared; the trap re-enters while set.
// - cpu level 7 masks all user levels; traps sit at levels 12-15 and pass it.
// - timed disable masks levels 1-6 for a period; level 7 stays live.
module priority_interrupt_controller (
	// system
	input wire logic clk_i,
	input wire logic rst_i,
	// wishbone slave
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [7:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	// event sources
	input wire logic [`IC_NSRC-1:0] src_event_i,
	input wire logic [`IC_NTRAP-1:0] trap_event_i,
	// processor core
	output ic_pkg::cpu_req_s cpu_req_o,
	input wire logic irq_ack_i,
	input wire logic return_from_irq_instr_i,
	output ic_pkg::level_t cpu_level_o,
	// host interrupt
	output logic irq_o
);
	import ic_pkg::*;

	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] nw, input logic [3:0] sel);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (sel[b]) begin
				r[b*8 +: 8] = nw[b*8 +: 8];
			end
		end
		return r;
	endfunction

	// scanning downward with >= lets the lowest index win a tie
	function automatic cpu_req_s pick(input logic [`IC_NCAND-1:0] valid,
		input level_t [`IC_NCAND-1:0] lvl);
		cpu_req_s r;
		r = '0;
		for (int i = `IC_NCAND - 1; i >= 0; i--) begin
			if (valid[i] && lvl[i] >= r.level) begin
				r.valid = 1'b1;
				r.level = lvl[i];
				r.vector = (i < `IC_NTRAP) ? 7'(i) :
					7'(i - `IC_NTRAP + `IC_USER_VEC_BASE);
			end
		end
		return r;
	endfunction

	prio_t [`IC_NSRC-1:0] prio_q, prio_d;
	logic [`IC_NSRC-1:0] pend_q, pend_d, en_q, en_d;
	logic [`IC_NTRAP-1:0] trap_q, trap_d;
	logic nest_dis_q, nest_dis_d, vsel_q, vsel_d, unack_q, unack_d;
	logic [15:0] timed_disable_instr_q, timed_disable_instr_d;
	logic [2:0] evt_q, evt_d, mask_q, mask_d;
	logic [6:0] last_ack_q, last_ack_d;
	level_t lvl_q, lvl_d;
	level_t stk_q [`IC_STACK_DEPTH];
	level_t stk_d [`IC_STACK_DEPTH];
	logic [3:0] sp_q, sp_d;
	cpu_req_s req_q, req_d, hp, win;
	logic ack_q, ack_d;
	logic [31:0] dat_q, dat_d, wdata;
	logic acc, wr, rd, take, pop, timed_disable_instr_on, wr_timed_disable_instr;
	logic [`IC_NCAND-1:0] cand, elig;
	level_t [`IC_NCAND-1:0] cand_lvl;

	assign ack_o = ack_q;
	assign dat_o = dat_q;
	assign cpu_req_o = req_q;
	assign cpu_level_o = lvl_q;
	assign irq_o = |(evt_q & mask_q);

	// a request completes on the edge where ack is already high
	assign acc = cyc_i & stb_i & ack_q;
	assign wr = acc & we_i;
	assign rd = acc & ~we_i;
	assign take = irq_ack_i & req_q.valid;
	assign pop = return_from_irq_instr_i & ~take & (sp_q != 4'h0);
	assign timed_disable_instr_on = timed_disable_instr_q != 16'h0;
	assign wr_timed_disable_instr = wr & (adr_i == `IC_OFF_TIMED_DISABLE_INSTR);

	// candidate table: traps first, then user sources
	always_comb begin
		cand = '0;
		elig = '0;
		cand_lvl = '0;
		for (int k = 0; k < `IC_NTRAP; k++) begin
			cand[k] = trap_q[k];
			cand_lvl[k] = `IC_TRAP_TOP_LVL - 4'(k);
		end
		for (int s = 0; s < `IC_NSRC; s++) begin
			cand[`IC_NTRAP+s] = pend_q[s] & en_q[s] &
				(prio_q[s] != 3'h0);
			cand_lvl[`IC_NTRAP+s] = {1'b0, prio_q[s]};
		end
		for (int c = 0; c < `IC_NCAND; c++) begin
			// traps sit above 7, so a level-7 cpu never blocks them
			elig[c] = cand[c] && cand_lvl[c] > lvl_q;
			if (c >= `IC_NTRAP && timed_disable_instr_on &&
				cand_lvl[c] <= `IC_TIMED_DISABLE_INSTR_TOP_LVL) begin
				elig[c] = 1'b0;
			end
		end
		hp = pick(cand, cand_lvl);
		win = pick(elig, cand_lvl);
	end

	// processor handshake, level stack and capture
	always_comb begin
		lvl_d = lvl_q;
		sp_d = sp_q;
		stk_d = stk_q;
		last_ack_d = last_ack_q;
		if (take) begin
			if (sp_q != 4'(`IC_STACK_DEPTH)) begin
				stk_d[sp_q[2:0]] = lvl_q;
				sp_d = sp_q + 4'h1;
			end
			lvl_d = (nest_dis_q && req_q.level <= `IC_USER_TOP_LVL) ?
				`IC_USER_TOP_LVL : req_q.level;
			last_ack_d = req_q.vector;
		end else if (pop) begin
			sp_d = sp_q - 4'h1;
			lvl_d = stk_q[sp_d[2:0]];
		end else if (wr && adr_i == `IC_OFF_SRL &&
			lvl_q <= `IC_USER_TOP_LVL) begin
			lvl_d = {1'b0, wdata[`IC_SRL_LVL_LSB +: 3]};
		end
		// a stale request is withdrawn on a take, a cpu level change or a timed disable write
		req_d = win;
		if (take || lvl_d != lvl_q || wr_timed_disable_instr) begin
			req_d.valid = 1'b0;
		end
		unack_d = hp.valid && hp.level <= lvl_q;
	end

	// register file
	always_comb begin
		logic [31:0] rv;
		rv = '0;
		prio_d = prio_q;
		pend_d = pend_q;
		en_d = en_q;
		trap_d = trap_q;
		nest_dis_d = nest_dis_q;
		vsel_d = vsel_q;
		mask_d = mask_q;
		timed_disable_instr_d = timed_disable_instr_on ? timed_disable_instr_q - 16'h1 : timed_disable_instr_q;
		wdata = '0;
		case (adr_i)
		`IC_OFF_CTRL1: begin
			rv[`IC_NEST_DIS_BIT] = nest_dis_q;
			rv[`IC_NTRAP-1:0] = trap_q;
		end
		`IC_OFF_PEND: rv[`IC_NSRC-1:0] = pend_q;
		`IC_OFF_ENABLE: rv[`IC_NSRC-1:0] = en_q;
		`IC_OFF_GFX_PRIO: rv[2:0] = prio_q[0];
		`IC_OFF_PRIO: begin
			for (int s = 1; s < `IC_NSRC; s++) begin
				rv[(s-1)*`IC_PRIO_STRIDE +: 3] = prio_q[s];
			end
		end
		`IC_OFF_TEST: begin
			rv[`IC_UNACK_BIT] = unack_q;
			rv[`IC_VSEL_BIT] = vsel_q;
			rv[11:8] = req_q.level;
			rv[6:0] = vsel_q ? hp.vector : last_ack_q;
		end
		`IC_OFF_SRL: rv[`IC_SRL_LVL_LSB +: 3] = lvl_q[2:0];
		`IC_OFF_TIMED_DISABLE_INSTR: rv[15:0] = timed_disable_instr_q;
		`IC_OFF_EVT: rv[2:0] = evt_q;
		`IC_OFF_MASK: rv[2:0] = mask_q;
		default: rv = '0;
		endcase
		wdata = merge(rv, dat_i, sel_i);
		if (wr) begin
			case (adr_i)
			`IC_OFF_CTRL1: begin
				nest_dis_d = wdata[`IC_NEST_DIS_BIT];
				trap_d = wdata[`IC_NTRAP-1:0];
			end
			`IC_OFF_PEND: pend_d = wdata[`IC_NSRC-1:0];
			`IC_OFF_ENABLE: en_d = wdata[`IC_NSRC-1:0];
			`IC_OFF_GFX_PRIO: prio_d[0] = wdata[2:0];
			`IC_OFF_PRIO: begin
				for (int s = 1; s < `IC_NSRC; s++) begin
					prio_d[s] = wdata[(s-1)*`IC_PRIO_STRIDE +: 3];
				end
			end
			`IC_OFF_TEST: vsel_d = wdata[`IC_VSEL_BIT];
			`IC_OFF_TIMED_DISABLE_INSTR: timed_disable_instr_d = wdata[15:0];
			`IC_OFF_MASK: mask_d = wdata[2:0];
			default: ;
			endcase
		end
		// new events win over a software clear in the same cycle
		pend_d = pend_d | src_event_i;
		trap_d = trap_d | trap_event_i;
		// read clears only the bits that the reader actually saw
		evt_d = rd && adr_i == `IC_OFF_EVT ? evt_q & ~dat_q[2:0] : evt_q;
		evt_d[`IC_EVT_TRAP] = evt_d[`IC_EVT_TRAP] | (|trap_event_i);
		evt_d[`IC_EVT_ACK] = evt_d[`IC_EVT_ACK] | take;
		evt_d[`IC_EVT_BLOCK] = evt_d[`IC_EVT_BLOCK] | (unack_d & ~unack_q);
		ack_d = cyc_i & stb_i & ~ack_q;
		dat_d = ack_d ? rv : dat_q;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			for (int s = 0; s < `IC_NSRC; s++) begin
				prio_q[s] <= `IC_PRIO_RST;
			end
			pend_q <= '0;
			en_q <= '0;
			trap_q <= '0;
			nest_dis_q <= 1'b0;
			vsel_q <= 1'b0;
			unack_q <= 1'b0;
			timed_disable_instr_q <= '0;
			evt_q <= '0;
			mask_q <= '0;
			last_ack_q <= '0;
			lvl_q <= '0;
			for (int d = 0; d < `IC_STACK_DEPTH; d++) begin
				stk_q[d] <= '0;
			end
			sp_q <= '0;
			req_q <= '0;
			ack_q <= 1'b0;
			dat_q <= '0;
		end else begin
			prio_q <= prio_d;
			pend_q <= pend_d;
			en_q <= en_d;
			trap_q <= trap_d;
			nest_dis_q <= nest_dis_d;
			vsel_q <= vsel_d;
			unack_q <= unack_d;
			timed_disable_instr_q <= timed_disable_instr_d;
			evt_q <= evt_d;
			mask_q <= mask_d;
			last_ack_q <= last_ack_d;
			lvl_q <= lvl_d;
			stk_q <= stk_d;
			sp_q <= sp_d;
			req_q <= req_d;
			ack_q <= ack_d;
			dat_q <= dat_d;
		end
	end

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	logic rd_test_start;
	level_t stack_top;
	assign rd_test_start = cyc_i & stb_i & ~ack_q & ~we_i &
		(adr_i == `IC_OFF_TEST);
	assign stack_top = stk_q[3'(sp_q - 4'h1)];

	property p_prio_reset;
		rst_i |=> prio_q[0] == `IC_PRIO_RST &&
			prio_q[`IC_NSRC-1] == `IC_PRIO_RST;
	endproperty
	a_prio_reset: assert property (disable iff (1'b0) p_prio_reset)
		else $error("priority not at level 4 after reset");

	property p_no_zero_level;
		cpu_req_o.valid |-> cpu_req_o.level != 4'h0;
	endproperty
	a_no_zero_level: assert property (p_no_zero_level)
		else $error("request presented with priority zero");

	property p_gfx_upper_zero;
		ack_o && !we_i && adr_i == `IC_OFF_GFX_PRIO |-> dat_o[31:3] == '0;
	endproperty
	a_gfx_upper_zero: assert property (p_gfx_upper_zero)
		else $error("graphics priority upper bits not zero");

	property p_unack_flag;
		##1 unack_q == $past(hp.valid && hp.level <= lvl_q);
	endproperty
	a_unack_flag: assert property (p_unack_flag)
		else $error("unacknowledged flag does not follow blocked request");

	property p_vector_select;
		rd_test_start |=> dat_o[6:0] ==
			($past(vsel_q) ? $past(hp.vector) : $past(last_ack_q));
	endproperty
	a_vector_select: assert property (p_vector_select)
		else $error("vector field does not match capture select");

	property p_vector_range;
		rd_test_start |=> dat_o[7] == 1'b0 && dat_o[6:0] <= `IC_VEC_MAX &&
			dat_o[11:8] == $past(req_q.level);
	endproperty
	a_vector_range: assert property (p_vector_range)
		else $error("test register vector or level field wrong");

	property p_take_above;
		irq_ack_i && cpu_req_o.valid |-> cpu_req_o.level > cpu_level_o
			##1 last_ack_q == $past(cpu_req_o.vector);
	endproperty
	a_take_above: assert property (p_take_above)
		else $error("request taken at or below cpu level");

	property p_return_restores;
		pop |=> cpu_level_o == $past(stack_top) && sp_q == $past(sp_q) - 4'h1;
	endproperty
	a_return_restores: assert property (p_return_restores)
		else $error("return did not restore previous level");

	property p_trap_sticky;
		trap_q[0] && !(wr && adr_i == `IC_OFF_CTRL1) |=> trap_q[0];
	endproperty
	a_trap_sticky: assert property (p_trap_sticky)
		else $error("trap flag dropped without software clear");

	property p_pend_sticky;
		pend_q[0] && !(wr && adr_i == `IC_OFF_PEND) |=> pend_q[0];
	endproperty
	a_pend_sticky: assert property (p_pend_sticky)
		else $error("pending flag dropped without software clear");

	property p_timed_disable_instr_mask;
		timed_disable_instr_on && $past(timed_disable_instr_on) && cpu_req_o.valid |->
			cpu_req_o.level >= `IC_USER_TOP_LVL;
	endproperty
	a_timed_disable_instr_mask: assert property (p_timed_disable_instr_mask)
		else $error("level 1-6 request during timed disable");

	c_take: cover property (take ##[1:20] pop);
	c_blocked: cover property ($rose(unack_q));
	c_trap_over_seven: cover property (take && lvl_q == `IC_USER_TOP_LVL);
endmodule // priority_interrupt_controller

// ===== shared/ic_map.svh
// register offsets, field positions, reset values and sizes of the controller
`ifndef IC_MAP_SVH
`define IC_MAP_SVH
`define IC_NSRC 8
`define IC_NTRAP 4
`define IC_NCAND 12
`define IC_USER_VEC_BASE 8
`define IC_TRAP_TOP_LVL 4'hf
`define IC_USER_TOP_LVL 4'h7
`define IC_TIMED_DISABLE_INSTR_TOP_LVL 4'h6
`define IC_VEC_MAX 7'h76
`define IC_PRIO_RST 3'h4
`define IC_PRIO_STRIDE 4
`define IC_STACK_DEPTH 8
`define IC_OFF_CTRL1 8'h00
`define IC_OFF_PEND 8'h04
`define IC_OFF_ENABLE 8'h08
`define IC_OFF_GFX_PRIO 8'h0c
`define IC_OFF_PRIO 8'h10
`define IC_OFF_TEST 8'h14
`define IC_OFF_SRL 8'h18
`define IC_OFF_TIMED_DISABLE_INSTR 8'h1c
`define IC_OFF_EVT 8'h20
`define IC_OFF_MASK 8'h24
`define IC_NEST_DIS_BIT 15
`define IC_UNACK_BIT 15
`define IC_VSEL_BIT 13
`define IC_SRL_LVL_LSB 1
`define IC_EVT_TRAP 0
`define IC_EVT_ACK 1
`define IC_EVT_BLOCK 2
`endif

// ===== shared/ic_pkg.sv
// types shared by the interrupt controller and its users
package ic_pkg;
	// request presented to the processor core
	typedef struct packed {
		logic valid;
		logic [3:0] level;
		logic [6:0] vector;
	} cpu_req_s;
	typedef logic [2:0] prio_t;
	typedef logic [3:0] level_t;
endpackage

// ===== tb/cpu_core_model.sv
// processor core model that takes vectored requests
`timescale 1ns/100ps
module cpu_core_model (
	// system
	input wire logic clk_i,
	input wire logic rst_i,
	// request side
	input wire ic_pkg::cpu_req_s cpu_req_i,
	input wire logic slow_i,
	output logic irq_ack_o,
	output logic took_o,
	output logic [6:0] took_vec_o
);
	import ic_pkg::*;
	logic [1:0] wait_q;
	// slow mode lets a request stand four cycles before the ack, one in fast mode
	always_ff @(posedge clk_i) begin
		irq_ack_o <= 1'b0;
		took_o <= 1'b0;
		if (rst_i || !cpu_req_i.valid || irq_ack_o) begin
			wait_q <= 2'h0;
		end else if (!slow_i || wait_q == 2'h3) begin
			irq_ack_o <= 1'b1;
			took_o <= 1'b1;
			took_vec_o <= cpu_req_i.vector;
		end else begin
			wait_q <= wait_q + 2'h1;
		end
	end
endmodule // cpu_core_model

// ===== tb/tb.sv
// self-checking bench of the priority interrupt controller
`timescale 1ns/100ps
`include "ic_map.svh"
`define CHK(g, e) begin \
	n_checks++; \
	if ((g) !== (e)) begin \
		failures++; \
		$display("ERROR %0t: got %h want %h", $time, g, e); \
	end \
end
module tb;
	import ic_pkg::*;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic cyc_i = 1'b0;
	logic stb_i = 1'b0;
	logic we_i = 1'b0;
	logic [7:0] adr_i = 8'h00;
	logic [3:0] sel_i = 4'h0;
	logic [31:0] dat_i = 32'h0;
	logic [31:0] dat_o;
	logic ack_o;
	logic [7:0] src = 8'h00;
	logic [3:0] trap = 4'h0;
	cpu_req_s cpu_req_o;
	logic irq_ack;
	logic ret = 1'b0;
	level_t cpu_level_o;
	logic irq_o;
	logic slow = 1'b0;
	logic took;
	logic [6:0] tvec;
	logic [6:0] vx;
	logic [31:0] mx;
	logic [31:0] ex;
	logic [31:0] rq[$];
	logic [31:0] mq[$];
	logic [6:0] vq[$];
	logic [15:0] r = 16'h0022;
	int failures = 0;
	int n_checks = 0;
	always #20 clk_i = ~clk_i;
	priority_interrupt_controller uut (.clk_i(clk_i), .rst_i(rst_i),
		.cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
		.sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
		.src_event_i(src), .trap_event_i(trap), .cpu_req_o(cpu_req_o),
		.irq_ack_i(irq_ack), .return_from_irq_instr_i(ret),
		.cpu_level_o(cpu_level_o), .irq_o(irq_o));
	cpu_core_model core (.clk_i(clk_i), .rst_i(rst_i), .cpu_req_i(cpu_req_o),
		.slow_i(slow), .irq_ack_o(irq_ack), .took_o(took), .took_vec_o(tvec));
	function automatic logic [15:0] lfsr(input logic [15:0] v);
		return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
	endfunction
	task final_report;
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	// request held until the edge that sees ack, then released
	task automatic bus(input logic w, input logic [7:0] a,
		input logic [31:0] d, input logic [3:0] s = 4'hf);
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i <= w;
		adr_i <= a;
		dat_i <= d;
		sel_i <= s;
		// only the watchdog ends a wait for ack
		do begin
			@(posedge clk_i);
		end while (ack_o !== 1'b1);
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
		@(posedge clk_i);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e, m);
		rq.push_back(e);
		mq.push_back(m);
		bus(1'b0, a, 32'h0);
	endtask
	task automatic ev(input logic [7:0] s, input logic [3:0] t, int n);
		src <= s;
		trap <= t;
		@(posedge clk_i);
		src <= 8'h00;
		trap <= 4'h0;
		repeat (n) @(posedge clk_i);
	endtask
	task automatic rti(int n);
		ret <= 1'b1;
		@(posedge clk_i);
		ret <= 1'b0;
		repeat (n) @(posedge clk_i);
	endtask
	always @(posedge clk_i) begin
		if (ack_o === 1'b1 && we_i === 1'b0 && rq.size() > 0) begin
			mx = mq.pop_front();
			ex = rq.pop_front();
			`CHK(dat_o & mx, ex)
		end
		if (took === 1'b1) begin
			vx = vq.size() > 0 ? vq.pop_front() : 7'h7f;
			`CHK(tvec, vx)
		end
	end
	initial begin
		repeat (3000) @(posedge clk_i);
		failures++;
		final_report;
	end
	initial begin
		repeat (4) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		rd(`IC_OFF_GFX_PRIO, 32'h4, '1);
		rd(`IC_OFF_PRIO, 32'h0444_4444, '1);
		rd(`IC_OFF_TEST, 32'h0, '1);
		rd(8'h3c, 32'h0, '1);
		r = lfsr(r);
		bus(1'b1, `IC_OFF_GFX_PRIO, {16'h0, r});
		rd(`IC_OFF_GFX_PRIO, {29'h0, r[2:0]}, '1);
		bus(1'b1, `IC_OFF_GFX_PRIO, 32'h5);
		// lanes 1-3 only: the priority byte must keep its value
		bus(1'b1, `IC_OFF_GFX_PRIO, 32'hffff_fff8, 4'he);
		rd(`IC_OFF_GFX_PRIO, 32'h5, '1);
		bus(1'b1, `IC_OFF_PRIO, 32'h0444_6705);
		rd(`IC_OFF_PRIO, 32'h0444_6705, '1);
		bus(1'b1, `IC_OFF_PEND, 32'h0);
		bus(1'b1, `IC_OFF_ENABLE, 32'hff);
		bus(1'b1, `IC_OFF_MASK, 32'h2);
		vq.push_back(7'h08);
		ev(8'h03, 4'h0, 6);
		`CHK(cpu_level_o, 4'h5)
		`CHK(irq_o, 1'b1)
		rd(`IC_OFF_EVT, 32'h2, 32'h2);
		`CHK(irq_o, 1'b0)
		vq.push_back(7'h08);
		rti(6);
		bus(1'b1, `IC_OFF_PRIO, 32'h0444_6704);
		bus(1'b1, `IC_OFF_PEND, 32'h2);
		rd(`IC_OFF_TEST, 32'h8008, 32'ha0ff);
		bus(1'b1, `IC_OFF_TEST, 32'h2000);
		rd(`IC_OFF_TEST, 32'ha009, 32'ha0ff);
		vq.push_back(7'h09);
		rti(6);
		`CHK(cpu_level_o, 4'h4)
		bus(1'b1, `IC_OFF_PEND, 32'h0);
		rti(3);
		`CHK(cpu_level_o, 4'h0)
		ev(8'h04, 4'h0, 8);
		`CHK(cpu_req_o.valid, 1'b0)
		rd(`IC_OFF_PEND, 32'h4, 32'h4);
		bus(1'b1, `IC_OFF_PEND, 32'h0);
		bus(1'b1, `IC_OFF_SRL, 32'h0e);
		ev(8'h08, 4'h0, 6);
		`CHK(cpu_req_o.valid, 1'b0)
		slow <= 1'b1;
		vq.push_back(7'h03);
		ev(8'h00, 4'h8, 1);
		rd(`IC_OFF_TEST, 32'h2c03, 32'hafff);
		repeat (6) @(posedge clk_i);
		`CHK(cpu_level_o, 4'hc)
		rd(`IC_OFF_CTRL1, 32'h8, 32'h8);
		bus(1'b1, `IC_OFF_CTRL1, 32'h0);
		rti(3);
		`CHK(cpu_level_o, 4'h7)
		bus(1'b1, `IC_OFF_PEND, 32'h0);
		bus(1'b1, `IC_OFF_SRL, 32'h0);
		slow <= 1'b0;
		// level 7 passes the timed mask, level 6 waits it out
		bus(1'b1, `IC_OFF_TIMED_DISABLE_INSTR, 32'h64);
		vq.push_back(7'h0b);
		ev(8'h18, 4'h0, 6);
		bus(1'b1, `IC_OFF_PEND, 32'h10);
		rti(3);
		`CHK(cpu_req_o.valid, 1'b0)
		vq.push_back(7'h0c);
		repeat (100) @(posedge clk_i);
		`CHK(cpu_level_o, 4'h6)
		bus(1'b1, `IC_OFF_PEND, 32'h0);
		rti(3);
		bus(1'b1, `IC_OFF_CTRL1, 32'h8000);
		vq.push_back(7'h0c);
		ev(8'h10, 4'h0, 6);
		`CHK(cpu_level_o, 4'h7)
		bus(1'b1, `IC_OFF_PEND, 32'h0);
		rti(3);
		`CHK(cpu_level_o, 4'h0)
		`CHK(vq.size(), 0)
		final_report;
	end
endmodule // tb
